// *** bench/pief_evt_src.sv ***
// peripheral event sources feeding the pending-flag inputs
`timescale 1ns/10ps

module pief_evt_src (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] fire,
  output      logic [7:0] pending_set
);
  // events launch on the edge after the request, like a peripheral's own flop
  always_ff @(posedge clk) begin
    pending_set <= rst_n ? fire : 8'h00;
  end
endmodule

// *** bench/pief_irq_bank_sva.sv ***
// port assertions for the peripheral interrupt bank
`timescale 1ns/10ps
`include "pief_consts.svh"

module pief_irq_bank_sva #(
  parameter int WIDTH = 8
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire pief_pkg::pief_apb_req_t apb_req,
  input wire pief_pkg::pief_apb_rsp_t apb_rsp,
  input wire logic [WIDTH-1:0]        pending_set,
  input wire pief_pkg::pief_enables_t enables,
  input wire logic                    global_irq_gate,
  input wire logic                    periph_irq_gate,
  input wire logic                    periph_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_hit;
  // write completing at this edge
  assign wr_hit = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;

  a_one_wait: assert property ($rose(apb_req.penable) |=> apb_rsp.pready) else $error("no answer after one wait");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready held");
  a_rdata_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0) else $error("data outside answer");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("error without ready");
  a_unused_bits: assert property ((enables.en2 & 8'h90) == 8'h00 && (enables.en3 & 8'hCC) == 8'h00
    && (enables.en5 & 8'h08) == 8'h00) else $error("unused enable bit set");
  a_en2_write: assert property (wr_hit && apb_req.paddr == `PIEF_OFF_EN2 |=>
    enables.en2 == ($past(apb_req.pwdata[7:0]) & `PIEF_MASK_EN2)) else $error("enable two write lost");
  a_gate_write: assert property (wr_hit && apb_req.paddr == `PIEF_OFF_CTRL |=>
    global_irq_gate == $past(apb_req.pwdata[7]) && periph_irq_gate == $past(apb_req.pwdata[6])) else $error("gate");
  a_en_hold: assert property (!wr_hit |=> $stable(enables)) else $error("enables moved without write");
  a_gate_block: assert property (!(global_irq_gate && periph_irq_gate) |=> !periph_irq) else $error("irq leak");
  a_irq_cause: assert property (periph_irq |-> $past(|enables.en1 && global_irq_gate && periph_irq_gate))
    else $error("irq without cause");
  // an enabled event seen at an edge must show on the request two edges later, gates untouched meanwhile
  a_event_irq: assert property ((|(pending_set & enables.en1)) && global_irq_gate && periph_irq_gate && !wr_hit
    |-> ##2 periph_irq) else $error("enabled event gave no irq");

  cover property ($rose(periph_irq));
  cover property (apb_rsp.pslverr);
  cover property (wr_hit && apb_req.paddr == `PIEF_OFF_CTRL);
endmodule

bind pief_irq_bank pief_irq_bank_sva #(.WIDTH(WIDTH)) u_sva (.clk(clk), .rst_n(rst_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pending_set(pending_set), .enables(enables), .global_irq_gate(global_irq_gate),
  .periph_irq_gate(periph_irq_gate), .periph_irq(periph_irq));

// *** bench/pief_irq_bank_tb.sv ***
// self-checking bench of the peripheral interrupt bank
`timescale 1ns/10ps

module pief_irq_bank_tb;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [7:0]              fire = 8'h00;
  logic [7:0]              pending_set;
  pief_pkg::pief_apb_req_t req = '0;
  pief_pkg::pief_apb_rsp_t rsp;
  pief_pkg::pief_enables_t enables;
  logic                    g_gate, p_gate, irq, er;
  logic [31:0]             rd;
  logic [7:0]              m [8];
  logic [7:0]              msk [8] = '{8'hFF, 8'h6F, 8'h33, 8'hFF, 8'hF7, 8'hFF, 8'h00, 8'hC0};
  int                      n_fail = 0;
  int                      n_compared = 0;
  int                      cyc = 0;
  integer                  seed = 32'h5894168E;

  always #5 clk = ~clk;
  pief_evt_src u_pief_evt_src (.clk(clk), .rst_n(rst_n), .fire(fire), .pending_set(pending_set));
  pief_irq_bank u_pief_irq_bank (.clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .pending_set(pending_set), .enables(enables), .global_irq_gate(g_gate), .periph_irq_gate(p_gate),
    .periph_irq(irq));

  task conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      conclude;
    end
  end
  task chk(input logic [47:0] s, input logic [47:0] x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // apb master: request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task mwr(input int i, input logic [7:0] d);
    apb(1'b1, 8'(i * 4), d);
    if (i == 6) m[5] &= ~d;
    else m[i] = d & msk[i];
  endtask
  task mrd(input int i);
    apb(1'b0, 8'(i * 4), 8'h00);
    chk({rd, er}, {24'h0, m[i], 1'b0});
  endtask
  // outputs against the model two edges on, once the registered irq has caught up with a register write
  task cst;
    repeat (2) @(posedge clk);
    chk({enables, g_gate, p_gate, irq}, {m[0], m[1], m[2], m[3], m[4], m[7][7], m[7][6],
      m[7][7] & m[7][6] & (|(m[5] & m[0]))});
  endtask
  task ev(input logic [7:0] v);
    @(posedge clk) fire <= v;
    @(posedge clk) fire <= 8'h00;
    m[5] |= v;
  endtask
  // software write to request set one while a one-cycle event lands on the very edge the write takes effect;
  // the event source adds one flop, so fire rises one edge after the setup cycle starts
  task race(input logic [7:0] a, input logic [7:0] d, input logic [7:0] v);
    fork
      apb(1'b1, a, d);
      begin
        repeat (2) @(posedge clk);
        fire <= v;
        @(posedge clk) fire <= 8'h00;
      end
    join
  endtask
  task rsts;
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (m[i]) m[i] = 8'h00;
  endtask

  initial begin
    rsts;
    for (int i = 0; i < 8; i++) mrd(i);
    apb(1'b1, 8'h24, 8'hFF);
    chk({rd, er}, 48'h1);
    apb(1'b0, 8'h20, 8'h00);
    chk({rd, er}, 48'h1);
    cst;
    $display("test reset done");
    // random then all-ones to hit every reserved bit
    for (int p = 0; p < 2; p++) for (int i = 0; i < 8; i++) begin
      mwr(i, p ? 8'hFF : 8'($random(seed)));
      mrd(i);
    end
    cst;
    $display("test fields done");
    mwr(6, 8'hFF);
    mwr(0, 8'h00);
    mwr(7, 8'h00);
    ev(8'h81);
    mrd(5);
    mwr(0, 8'h01);
    cst;
    mwr(7, 8'h80);
    cst;
    mwr(7, 8'hC0);
    cst;
    mwr(7, 8'h40);
    cst;
    mwr(7, 8'hC0);
    mwr(5, 8'h00);
    cst;
    $display("test gating done");
    // a single-cycle event beats a zero write, then a clear, landing on the same edge
    race(8'h14, 8'h00, 8'h02);
    m[5] = 8'h02;
    mrd(5);
    race(8'h18, 8'h02, 8'h02);
    mrd(5);
    // request rises two edges after the event is seen, not sooner
    ev(8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    chk(irq, 1'b1);
    mwr(0, 8'hFF);
    repeat (4) begin
      ev(8'($random(seed)));
      cst;
      mrd(5);
    end
    $display("test events done");
    rsts;
    cst;
    mrd(5);
    $display("test rereset done");
    conclude;
  end
endmodule

// *** design/pief_consts.svh ***
// offsets, field positions, masks and reset values of the peripheral interrupt bank
`ifndef PIEF_CONSTS_SVH
`define PIEF_CONSTS_SVH

// register byte offsets on the apb window
`define PIEF_OFF_EN1     8'h00
`define PIEF_OFF_EN2     8'h04
`define PIEF_OFF_EN3     8'h08
`define PIEF_OFF_EN4     8'h0C
`define PIEF_OFF_EN5     8'h10
`define PIEF_OFF_REQ1    8'h14
`define PIEF_OFF_REQ1CLR 8'h18
`define PIEF_OFF_CTRL    8'h1C

// implemented-bit masks, unimplemented bits store nothing and read zero
`define PIEF_MASK_EN1    8'hFF
`define PIEF_MASK_EN2    8'h6F
`define PIEF_MASK_EN3    8'h33
`define PIEF_MASK_EN4    8'hFF
`define PIEF_MASK_EN5    8'hF7
`define PIEF_MASK_REQ1   8'hFF
`define PIEF_MASK_CTRL   8'hC0

// core interrupt control field positions
`define PIEF_BIT_GLOBAL_GATE 7
`define PIEF_BIT_PERIPH_GATE 6

// every implemented bit clears on any reset
`define PIEF_RST_BYTE    8'h00
`define PIEF_RST_WORD    32'h0000_0000

`endif

// *** design/pief_flag_bank.sv ***
// sticky pending-flag register, hardware set beats software clear
`timescale 1ns/10ps
`include "pief_consts.svh"

module pief_flag_bank #(
  parameter int          WIDTH = 8,
  parameter logic [7:0]  MASK  = `PIEF_MASK_REQ1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] hw_set,
  input  wire logic             sw_write,
  input  wire logic             sw_clear,
  input  wire logic [WIDTH-1:0] sw_data,
  output      logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } pief_flag_state_t;

  pief_flag_state_t cur;
  pief_flag_state_t next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // software write or clear first, then hardware set ors on top so no event is lost
  always_comb begin
    next_cur = cur;
    if (sw_write) begin
      next_cur.flags = sw_data;                       // writing zero clears, see [RULE_13]
    end else if (sw_clear) begin
      next_cur.flags = cur.flags & ~sw_data;
    end
    next_cur.flags = (next_cur.flags | hw_set) & MASK[WIDTH-1:0]; // see [RULE_02] see [RULE_13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronous reset to all clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur.flags <= '0;                                // see [RULE_05]
    end else begin
      cur <= next_cur;
    end
  end

  assign flags = cur.flags;

endmodule

// *** design/pief_irq_bank.sv ***
// peripheral interrupt enable bank, first request register and gated core request
// Operation
// [RULE_01] no peripheral request reaches the core while the peripheral gate is clear
// [RULE_02] flags set on their source event regardless of enables or gates
// [RULE_03] software clears stale flags before enabling the matching source
// [RULE_04] unimplemented bits ignore writes and read back zero
// [RULE_05] all enable and flag bits clear on every reset
// [RULE_06] enable set two: bits 6,5,3,2,1,0 used; bits 7 and 4 absent
// [RULE_07] enable set three: bits 5,4,1,0 used; bits 7-6 and 3-2 read zero
// [RULE_08] enable set four: all eight bits used
// [RULE_09] enable set five: bits 7-4 and 2-0 used; bit 3 absent
// [RULE_10] request set one: eight pending flags, one means pending
// [RULE_11] global gate set lets enabled interrupts through, clear blocks all
// [RULE_12] request raised when a flag and its enable are both set, gated
// [RULE_13] writing zero clears a flag; a same-cycle hardware set wins
`timescale 1ns/10ps
`include "pief_consts.svh"

module pief_irq_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire pief_pkg::pief_apb_req_t apb_req,
  output      pief_pkg::pief_apb_rsp_t apb_rsp,
  input  wire logic [WIDTH-1:0]       pending_set,
  output      pief_pkg::pief_enables_t enables,
  output      logic                   global_irq_gate,
  output      logic                   periph_irq_gate,
  output      logic                   periph_irq
);

  // register selector codes
  localparam logic [3:0] SEL_EN1  = 4'h0;
  localparam logic [3:0] SEL_EN2  = 4'h1;
  localparam logic [3:0] SEL_EN3  = 4'h2;
  localparam logic [3:0] SEL_EN4  = 4'h3;
  localparam logic [3:0] SEL_EN5  = 4'h4;
  localparam logic [3:0] SEL_REQ  = 4'h5;
  localparam logic [3:0] SEL_CLR  = 4'h6;
  localparam logic [3:0] SEL_CTRL = 4'h7;
  localparam logic [3:0] SEL_NONE = 4'hF;

  typedef struct packed {
    pief_pkg::pief_apb_state_t phase;
    pief_pkg::pief_enables_t   en;
    logic                      global_gate;
    logic                      periph_gate;
    logic                      irq;
    pief_pkg::pief_apb_rsp_t   rsp;
  } pief_bank_state_t;

  pief_bank_state_t cur;
  pief_bank_state_t next_cur;

  logic [WIDTH-1:0] flags;
  logic [3:0]       sel;
  logic             do_write;
  logic [7:0]       wbyte;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and the write path
  function automatic logic [3:0] decode(input logic [7:0] addr);
    logic [3:0] s;
    s = SEL_NONE;
    if (addr == `PIEF_OFF_EN1) begin
      s = SEL_EN1;
    end else if (addr == `PIEF_OFF_EN2) begin
      s = SEL_EN2;
    end else if (addr == `PIEF_OFF_EN3) begin
      s = SEL_EN3;
    end else if (addr == `PIEF_OFF_EN4) begin
      s = SEL_EN4;
    end else if (addr == `PIEF_OFF_EN5) begin
      s = SEL_EN5;
    end else if (addr == `PIEF_OFF_REQ1) begin
      s = SEL_REQ;
    end else if (addr == `PIEF_OFF_REQ1CLR) begin
      s = SEL_CLR;
    end else if (addr == `PIEF_OFF_CTRL) begin
      s = SEL_CTRL;
    end
    return s;
  endfunction

  // keep only implemented bits on write and on read-back
  function automatic logic [7:0] keep(input logic [7:0] value, input logic [7:0] mask);
    return value & mask;                              // see [RULE_04]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // a write lands only on the edge where the master sees pready high
  assign sel      = decode(apb_req.paddr);
  assign do_write = apb_req.psel && apb_req.penable && apb_req.pwrite
                    && (cur.phase == pief_pkg::PIEF_ST_ACK);
  assign wbyte    = apb_req.pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // request set one, sticky flags; the clear register is write-one-to-clear
  pief_flag_bank #(
    .WIDTH (WIDTH),
    .MASK  (`PIEF_MASK_REQ1)
  ) u_req1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .hw_set   (pending_set),                          // see [RULE_10]
    .sw_write (do_write && (sel == SEL_REQ)),
    .sw_clear (do_write && (sel == SEL_CLR)),
    .sw_data  (wbyte[WIDTH-1:0]),
    .flags    (flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb phase, register writes, read mux and the gated request
  always_comb begin
    next_cur            = cur;
    next_cur.rsp.pready = 1'b0;
    // one wait state lets prdata and pready both leave flip-flops
    case (cur.phase)
      pief_pkg::PIEF_ST_IDLE: begin
        if (apb_req.psel && apb_req.penable) begin
          next_cur.phase       = pief_pkg::PIEF_ST_ACK;
          next_cur.rsp.pready  = 1'b1;
          next_cur.rsp.pslverr = (sel == SEL_NONE);
          next_cur.rsp.prdata  = `PIEF_RST_WORD;
          if (!apb_req.pwrite) begin
            if (sel == SEL_EN1) begin
              next_cur.rsp.prdata[7:0] = keep(cur.en.en1, `PIEF_MASK_EN1);
            end else if (sel == SEL_EN2) begin
              next_cur.rsp.prdata[7:0] = keep(cur.en.en2, `PIEF_MASK_EN2); // see [RULE_06]
            end else if (sel == SEL_EN3) begin
              next_cur.rsp.prdata[7:0] = keep(cur.en.en3, `PIEF_MASK_EN3); // see [RULE_07]
            end else if (sel == SEL_EN4) begin
              next_cur.rsp.prdata[7:0] = keep(cur.en.en4, `PIEF_MASK_EN4); // see [RULE_08]
            end else if (sel == SEL_EN5) begin
              next_cur.rsp.prdata[7:0] = keep(cur.en.en5, `PIEF_MASK_EN5); // see [RULE_09]
            end else if (sel == SEL_REQ) begin
              next_cur.rsp.prdata[7:0] = keep(flags, `PIEF_MASK_REQ1);     // see [RULE_10]
            end else if (sel == SEL_CTRL) begin
              next_cur.rsp.prdata[`PIEF_BIT_GLOBAL_GATE] = cur.global_gate;
              next_cur.rsp.prdata[`PIEF_BIT_PERIPH_GATE] = cur.periph_gate;
            end
          end
        end
      end
      pief_pkg::PIEF_ST_ACK: begin
        next_cur.phase       = pief_pkg::PIEF_ST_IDLE;
        next_cur.rsp.pslverr = 1'b0;
        next_cur.rsp.prdata  = `PIEF_RST_WORD;
      end
      default: begin
        next_cur.phase = pief_pkg::PIEF_ST_IDLE;
      end
    endcase

    // enable and gate writes, unmapped writes are dropped
    if (do_write) begin
      if (sel == SEL_EN1) begin
        next_cur.en.en1 = keep(wbyte, `PIEF_MASK_EN1);
      end else if (sel == SEL_EN2) begin
        next_cur.en.en2 = keep(wbyte, `PIEF_MASK_EN2); // see [RULE_06] see [RULE_04]
      end else if (sel == SEL_EN3) begin
        next_cur.en.en3 = keep(wbyte, `PIEF_MASK_EN3); // see [RULE_07]
      end else if (sel == SEL_EN4) begin
        next_cur.en.en4 = keep(wbyte, `PIEF_MASK_EN4); // see [RULE_08]
      end else if (sel == SEL_EN5) begin
        next_cur.en.en5 = keep(wbyte, `PIEF_MASK_EN5); // see [RULE_09]
      end else if (sel == SEL_CTRL) begin
        next_cur.global_gate = wbyte[`PIEF_BIT_GLOBAL_GATE];
        next_cur.periph_gate = wbyte[`PIEF_BIT_PERIPH_GATE];
      end
    end

    // request follows flags one cycle later; enables alone never raise it
    next_cur.irq = cur.global_gate                    // see [RULE_11]
                   && cur.periph_gate                 // see [RULE_01]
                   && (|(flags & cur.en.en1));        // see [RULE_12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronous reset, everything cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur.phase       <= pief_pkg::PIEF_ST_IDLE;
      cur.en          <= '0;                          // see [RULE_05]
      cur.global_gate <= 1'b0;
      cur.periph_gate <= 1'b0;
      cur.irq         <= 1'b0;
      cur.rsp         <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign apb_rsp         = cur.rsp;
  assign enables         = cur.en;
  assign global_irq_gate = cur.global_gate;
  assign periph_irq_gate = cur.periph_gate;
  assign periph_irq      = cur.irq;

endmodule

// *** design/pief_pkg.sv ***
// types shared by the peripheral interrupt bank and its bench
package pief_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pief_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pief_apb_rsp_t;

  // enable sets handed to the peripherals and the irq path
  typedef struct packed {
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] en3;
    logic [7:0] en4;
    logic [7:0] en5;
  } pief_enables_t;

  // apb access phase tracker
  typedef enum logic [1:0] {
    PIEF_ST_IDLE = 2'b01,
    PIEF_ST_ACK  = 2'b10
  } pief_apb_state_t;

endpackage
